// [core/sctp_params.svh]
// Notes on behaviour
// - One-bit bypass path between serial in and out
// - No boundary-scan cells or boundary register
// - Boundary-scan instructions fall back to bypass
// - Identification register readable over serial path
// - Six further selectable data registers
// - Status register captures twelve comparator outputs
// - Instruction register selects data register and operation
// - Program instruction copies register into nonvolatile cells
// - Selected register shifts out for verification
// - Data registers carry analog and logic bits
// - Controller steps on test clock, steered by mode
// - Works correctly inside a standard serial chain
// - Six-bit instruction; ones or top bit mean bypass
// - Instruction capture loads identification instruction
// - Sample inputs on rising, drive out on falling
// - Status register twelve bits, one per comparator
`ifndef SCTP_PARAMS_SVH
`define SCTP_PARAMS_SVH

// ==========================================================
// Widths
`define SCTP_IR_W       6
`define SCTP_SH_W       81
`define SCTP_LEN_W      7
`define SCTP_CMP_N      12
`define SCTP_PLD_ROWS   75
`define SCTP_PLD_W      81
`define SCTP_CFG_AW     4
`define SCTP_CFG_W      41
`define SCTP_UES_W      16
`define SCTP_ID_W       32
`define SCTP_TLR_HIGHS  5

// ==========================================================
// Serial lengths of each data path
`define SCTP_LEN_BYP    7'h01
`define SCTP_LEN_ID     7'h20
`define SCTP_LEN_PADDR  7'h4B
`define SCTP_LEN_PDATA  7'h51
`define SCTP_LEN_CADDR  7'h04
`define SCTP_LEN_CDATA  7'h29
`define SCTP_LEN_STAT   7'h0C
`define SCTP_LEN_UES    7'h10

// ==========================================================
// Instruction codes
`define SCTP_OP_EXTEST     6'h00
`define SCTP_OP_ADDR_PLD   6'h01
`define SCTP_OP_DATA_PLD   6'h02
`define SCTP_OP_ERASE_AND  6'h03
`define SCTP_OP_ERASE_ARCH 6'h04
`define SCTP_OP_PROG_PLD   6'h05
`define SCTP_OP_PROG_FUSE  6'h06
`define SCTP_OP_BYPASS_LO  6'h07
`define SCTP_OP_READ_PLD   6'h08
`define SCTP_OP_DISCHARGE  6'h09
`define SCTP_OP_ADDR_CFG   6'h0A
`define SCTP_OP_DATA_CFG   6'h0B
`define SCTP_OP_ERASE_CFG  6'h0C
`define SCTP_OP_PROG_CFG   6'h0D
`define SCTP_OP_READ_CFG   6'h0E
`define SCTP_OP_ERASE_ALL  6'h16
`define SCTP_OP_SAFE       6'h17
`define SCTP_OP_PROG_EN    6'h18
`define SCTP_OP_IDCODE     6'h19
`define SCTP_OP_PROG_DIS   6'h1A
`define SCTP_OP_STATUS     6'h1B
`define SCTP_OP_SAMPLE     6'h1C
`define SCTP_OP_ERASE_UES  6'h1D
`define SCTP_OP_SHIFT_UES  6'h1E
`define SCTP_OP_PROG_UES   6'h1F
`define SCTP_OP_BYPASS     6'h3F

// ==========================================================
// Reset and identity values
`define SCTP_ID_DEFAULT    32'h0ABC_D001
`define SCTP_ERASED_BIT    1'b1

`endif

// [core/sctp_pkg.sv]
package sctp_pkg;

  // ==========================================================
  // Controller states, one-hot
  typedef enum logic [15:0] {
    SCTP_TLR  = 16'h0001,
    SCTP_RTI  = 16'h0002,
    SCTP_SDR  = 16'h0004,
    SCTP_CDR  = 16'h0008,
    SCTP_SHDR = 16'h0010,
    SCTP_E1DR = 16'h0020,
    SCTP_PDR  = 16'h0040,
    SCTP_E2DR = 16'h0080,
    SCTP_UDR  = 16'h0100,
    SCTP_SIR  = 16'h0200,
    SCTP_CIR  = 16'h0400,
    SCTP_SHIR = 16'h0800,
    SCTP_E1IR = 16'h1000,
    SCTP_PIR  = 16'h2000,
    SCTP_E2IR = 16'h4000,
    SCTP_UIR  = 16'h8000
  } sctp_state_t;

  // ==========================================================
  // Link pins
  typedef struct packed {
    logic tms;
    logic tdi;
  } sctp_link_in_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } sctp_link_out_t;

endpackage : sctp_pkg

// [core/sctp_top.sv]
`timescale 1ns/1ps
`include "sctp_params.svh"

module sctp_top #(
  parameter logic [31:0] ID_CODE = `SCTP_ID_DEFAULT  // Arbitrary neutral value
) (
  // System clock domain
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  // Comparator outputs from the analog side
  input  wire logic [`SCTP_CMP_N-1:0]  cmp_in,
  // Serial link, own clock
  input  wire logic                    tck,
  input  wire sctp_pkg::sctp_link_in_t link_in,
  output sctp_pkg::sctp_link_out_t     link_out,
  // Outputs parked while configuring
  output logic                         safe_state
);
  import sctp_pkg::*;

  // ==========================================================
  // Reset synchronisers
  logic rs1_q, rs2_q, tr1_q, tr2_q;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) {rs1_q, rs2_q} <= 2'h0;
    else        {rs1_q, rs2_q} <= {1'b1, rs1_q};
  always_ff @(posedge tck or negedge rst_n)
    if (!rst_n) {tr1_q, tr2_q} <= 2'h0;
    else        {tr1_q, tr2_q} <= {1'b1, tr1_q};
  wire rst_s_n = rs2_q;
  wire trst_n  = tr2_q;

  // ==========================================================
  // Comparator filter and word hand-off, system domain
  logic [`SCTP_CMP_N-1:0] c1_q, c2_q, c3_q, filt_q, hold_q;
  logic                   req_q, ak1_q, ak2_q, ack_q;
  wire                    cmp_agree = (c2_q == c3_q);
  wire                    hs_idle   = (ak2_q == req_q);
  always_ff @(posedge clock or negedge rst_s_n)
    if (!rst_s_n)
    begin
      {c1_q, c2_q, c3_q, filt_q, hold_q} <= '0;
      {req_q, ak1_q, ak2_q}              <= 3'h0;
    end
    else if (ce)
    begin
      {c1_q, c2_q, c3_q} <= {cmp_in, c1_q, c2_q};
      if (cmp_agree) filt_q <= c3_q;
      {ak1_q, ak2_q} <= {ack_q, ak1_q};
      if (hs_idle)
      begin
        hold_q <= filt_q;
        req_q  <= ~req_q;
      end
    end

  // Link side receives the held word
  logic                   rq1_q, rq2_q;
  logic [`SCTP_CMP_N-1:0] cmp_tck_q;
  wire                    hs_new = (rq2_q != ack_q);
  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
    begin
      {rq1_q, rq2_q, ack_q} <= 3'h0;
      cmp_tck_q             <= '0;
    end
    else
    begin
      {rq1_q, rq2_q} <= {req_q, rq1_q};
      if (hs_new)
      begin
        cmp_tck_q <= hold_q;
        ack_q     <= rq2_q;
      end
    end

  // ==========================================================
  // Controller state machine
  sctp_state_t st_q, st_d;
  wire         tms = link_in.tms;
  wire         tdi = link_in.tdi;
  always_comb
  begin
    case (st_q)
      SCTP_TLR:  st_d = tms ? SCTP_TLR  : SCTP_RTI;
      SCTP_RTI:  st_d = tms ? SCTP_SDR  : SCTP_RTI;
      SCTP_SDR:  st_d = tms ? SCTP_SIR  : SCTP_CDR;
      SCTP_CDR:  st_d = tms ? SCTP_E1DR : SCTP_SHDR;
      SCTP_SHDR: st_d = tms ? SCTP_E1DR : SCTP_SHDR;
      SCTP_E1DR: st_d = tms ? SCTP_UDR  : SCTP_PDR;
      SCTP_PDR:  st_d = tms ? SCTP_E2DR : SCTP_PDR;
      SCTP_E2DR: st_d = tms ? SCTP_UDR  : SCTP_SHDR;
      SCTP_UDR:  st_d = tms ? SCTP_SDR  : SCTP_RTI;
      SCTP_SIR:  st_d = tms ? SCTP_TLR  : SCTP_CIR;
      SCTP_CIR:  st_d = tms ? SCTP_E1IR : SCTP_SHIR;
      SCTP_SHIR: st_d = tms ? SCTP_E1IR : SCTP_SHIR;
      SCTP_E1IR: st_d = tms ? SCTP_UIR  : SCTP_PIR;
      SCTP_PIR:  st_d = tms ? SCTP_E2IR : SCTP_PIR;
      SCTP_E2IR: st_d = tms ? SCTP_UIR  : SCTP_SHIR;
      SCTP_UIR:  st_d = tms ? SCTP_SDR  : SCTP_RTI;
      default:   st_d = SCTP_TLR;
    endcase
  end
  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n) st_q <= SCTP_TLR;
    else         st_q <= st_d;

  // ==========================================================
  // Instruction register
  logic [`SCTP_IR_W-1:0] ir_sh_q, ir_q;
  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
    begin
      ir_sh_q <= `SCTP_OP_IDCODE;
      ir_q    <= `SCTP_OP_IDCODE;
    end
    else if (st_q == SCTP_TLR) ir_q <= `SCTP_OP_IDCODE;
    else if (st_q == SCTP_CIR) ir_sh_q <= `SCTP_OP_IDCODE;
    else if (st_q == SCTP_SHIR) ir_sh_q <= {tdi, ir_sh_q[`SCTP_IR_W-1:1]};
    // Loaded on entry to update, so the idle-entry edge runs the new one
    else if ((st_q == SCTP_E1IR || st_q == SCTP_E2IR) && tms) ir_q <= ir_sh_q;

  // Decode; unlisted codes, boundary-scan codes and top bit fall to bypass
  wire ir_lo     = ~ir_q[`SCTP_IR_W-1];
  wire sel_id    = ir_lo && (ir_q == `SCTP_OP_IDCODE);
  wire sel_paddr = ir_lo && (ir_q == `SCTP_OP_ADDR_PLD);
  wire sel_pdata = ir_lo && (ir_q == `SCTP_OP_DATA_PLD || ir_q == `SCTP_OP_READ_PLD
                             || ir_q == `SCTP_OP_PROG_PLD);
  wire sel_caddr = ir_lo && (ir_q == `SCTP_OP_ADDR_CFG);
  wire sel_cdata = ir_lo && (ir_q == `SCTP_OP_DATA_CFG || ir_q == `SCTP_OP_READ_CFG
                             || ir_q == `SCTP_OP_PROG_CFG);
  wire sel_stat  = ir_lo && (ir_q == `SCTP_OP_STATUS);
  wire sel_ues   = ir_lo && (ir_q == `SCTP_OP_SHIFT_UES || ir_q == `SCTP_OP_PROG_UES);
  wire sel_byp   = ~(sel_id | sel_paddr | sel_pdata | sel_caddr
                     | sel_cdata | sel_stat | sel_ues);
  wire park_op   = ir_lo && (ir_q inside {[`SCTP_OP_ADDR_PLD:`SCTP_OP_PROG_FUSE],
                   [`SCTP_OP_READ_PLD:`SCTP_OP_READ_CFG], [`SCTP_OP_ERASE_ALL:
                   `SCTP_OP_PROG_EN], [`SCTP_OP_ERASE_UES:`SCTP_OP_ERASE_UES],
                   [`SCTP_OP_PROG_UES:`SCTP_OP_PROG_UES]});

  // ==========================================================
  // Data registers and nonvolatile cells
  logic [`SCTP_PLD_ROWS-1:0] paddr_q;
  logic [`SCTP_PLD_W-1:0]    pdata_q;
  logic [`SCTP_CFG_AW-1:0]   caddr_q;
  logic [`SCTP_CFG_W-1:0]    cdata_q;
  logic [`SCTP_UES_W-1:0]    ues_q, ues_mem;
  logic                      fuse_q, prog_en_q, park_q;
  logic [`SCTP_PLD_W-1:0]    pld_mem [0:`SCTP_PLD_ROWS-1];
  logic [`SCTP_CFG_W-1:0]    cfg_mem [0:(1<<`SCTP_CFG_AW)-1];

  // Lowest set bit of the one-hot row address
  function automatic logic [6:0] sctp_row(input logic [`SCTP_PLD_ROWS-1:0] a);
    sctp_row = 7'h00;
    for (int i = `SCTP_PLD_ROWS - 1; i >= 0; i--)
      if (a[i]) sctp_row = 7'(i);
  endfunction : sctp_row
  wire [6:0] prow = sctp_row(paddr_q);

  // Operations fire on entry to idle after an update
  wire exec   = (st_q == SCTP_UIR || st_q == SCTP_UDR) && !tms;
  wire wr_ok  = exec && prog_en_q;
  wire op_is_pp = (ir_q == `SCTP_OP_PROG_PLD);
  wire op_is_pc = (ir_q == `SCTP_OP_PROG_CFG);
  wire op_is_pu = (ir_q == `SCTP_OP_PROG_UES);
  wire er_pld = wr_ok && (ir_q == `SCTP_OP_ERASE_AND || ir_q == `SCTP_OP_ERASE_ARCH
                          || ir_q == `SCTP_OP_ERASE_ALL);
  wire er_cfg = wr_ok && (ir_q == `SCTP_OP_ERASE_CFG || ir_q == `SCTP_OP_ERASE_ALL);
  wire er_ues = wr_ok && (ir_q == `SCTP_OP_ERASE_UES || ir_q == `SCTP_OP_ERASE_ALL);

  always_ff @(posedge tck)
  begin
    for (int r = 0; r < `SCTP_PLD_ROWS; r++)
      if (er_pld) pld_mem[r] <= {`SCTP_PLD_W{`SCTP_ERASED_BIT}};
      else if (wr_ok && op_is_pp && prow == 7'(r)) pld_mem[r] <= pdata_q;
    for (int r = 0; r < (1 << `SCTP_CFG_AW); r++)
      if (er_cfg) cfg_mem[r] <= {`SCTP_CFG_W{`SCTP_ERASED_BIT}};
      else if (wr_ok && op_is_pc && caddr_q == `SCTP_CFG_AW'(r)) cfg_mem[r] <= cdata_q;
    if (er_ues) ues_mem <= {`SCTP_UES_W{`SCTP_ERASED_BIT}};
    else if (wr_ok && op_is_pu) ues_mem <= ues_q;
  end

  // ==========================================================
  // Shared shift path
  logic [`SCTP_SH_W-1:0]  sh_q, sh_shift;
  logic [`SCTP_LEN_W-1:0] dr_len;
  logic [`SCTP_SH_W-1:0]  dr_cap;
  assign dr_len = sel_id    ? `SCTP_LEN_ID    : sel_paddr ? `SCTP_LEN_PADDR :
                  sel_pdata ? `SCTP_LEN_PDATA : sel_caddr ? `SCTP_LEN_CADDR :
                  sel_cdata ? `SCTP_LEN_CDATA : sel_stat  ? `SCTP_LEN_STAT  :
                  sel_ues   ? `SCTP_LEN_UES   : `SCTP_LEN_BYP;
  assign dr_cap = sel_id    ? `SCTP_SH_W'(ID_CODE) :
                  sel_paddr ? `SCTP_SH_W'(paddr_q) : sel_pdata ? pdata_q :
                  sel_caddr ? `SCTP_SH_W'(caddr_q) : sel_cdata ? `SCTP_SH_W'(cdata_q) :
                  sel_stat  ? `SCTP_SH_W'(cmp_tck_q) :
                  sel_ues   ? `SCTP_SH_W'(fuse_q ? '0 : ues_mem) : '0;
  always_comb
  begin
    sh_shift = sh_q >> 1;
    sh_shift[dr_len - 7'h01] = tdi;
  end

  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
    begin
      sh_q    <= '0;
      paddr_q <= '0;
      pdata_q <= '0;
      caddr_q <= '0;
      cdata_q <= '0;
      ues_q   <= '0;
    end
    else if (st_q == SCTP_CDR) sh_q <= dr_cap;
    else if (st_q == SCTP_SHDR) sh_q <= sh_shift;
    else if (st_q == SCTP_UDR)
    begin
      if (sel_paddr) paddr_q <= sh_q[`SCTP_PLD_ROWS-1:0];
      if (sel_pdata) pdata_q <= sh_q[`SCTP_PLD_W-1:0];
      if (sel_caddr) caddr_q <= sh_q[`SCTP_CFG_AW-1:0];
      if (sel_cdata) cdata_q <= sh_q[`SCTP_CFG_W-1:0];
      if (sel_ues)   ues_q   <= sh_q[`SCTP_UES_W-1:0];
    end
    else if (exec && ir_q == `SCTP_OP_READ_PLD)
      pdata_q <= fuse_q ? '0 : pld_mem[prow];
    else if (exec && ir_q == `SCTP_OP_READ_CFG)
      cdata_q <= fuse_q ? '0 : cfg_mem[caddr_q];

  // Program enable, fuse and parking
  always_ff @(posedge tck or negedge trst_n)
    if (!trst_n)
    begin
      prog_en_q <= 1'b0;
      fuse_q    <= 1'b0;
      park_q    <= 1'b0;
    end
    else
    begin
      if (exec && ir_q == `SCTP_OP_PROG_EN) prog_en_q <= 1'b1;
      else if (exec && ir_q == `SCTP_OP_PROG_DIS) prog_en_q <= 1'b0;
      if (wr_ok && ir_q == `SCTP_OP_PROG_FUSE) fuse_q <= 1'b1;
      else if (er_pld && ir_q == `SCTP_OP_ERASE_ALL) fuse_q <= 1'b0;
      park_q <= park_op || prog_en_q;
    end

  // ==========================================================
  // Serial output on the falling edge
  wire shifting = (st_q == SCTP_SHDR) || (st_q == SCTP_SHIR);
  wire tdo_bit  = (st_q == SCTP_SHIR) ? ir_sh_q[0] : sh_q[0];
  always_ff @(negedge tck or negedge trst_n)
    if (!trst_n) link_out <= '0;
    else         link_out <= '{tdo: tdo_bit, tdo_oe: shifting};

  // Park request crosses into the system domain
  logic pk1_q;
  always_ff @(posedge clock or negedge rst_s_n)
    if (!rst_s_n) {pk1_q, safe_state} <= 2'h0;
    else if (ce)  {pk1_q, safe_state} <= {park_q, pk1_q};

  // ==========================================================
  // Checks
  sequence s_mode_high5;
    tms [*5];
  endsequence
  sequence s_ir_update;
    st_q == SCTP_UIR ##1 1'b1;
  endsequence

  AST_TLR_FIVE: assert property (@(posedge tck) disable iff (!trst_n)
    s_mode_high5 |=> st_q == SCTP_TLR)
    else $error("Five high mode samples did not reach reset state");
  AST_LEAVE_TLR: assert property (@(posedge tck) disable iff (!trst_n)
    (st_q == SCTP_TLR && !tms) |=> st_q == SCTP_RTI)
    else $error("Reset state did not move to idle");
  AST_CAP_ID: assert property (@(posedge tck) disable iff (!trst_n)
    st_q == SCTP_CIR |=> ir_sh_q == `SCTP_OP_IDCODE)
    else $error("Instruction capture did not load identification code");
  AST_IR_UPD: assert property (@(posedge tck) disable iff (!trst_n)
    s_ir_update |-> ir_q == $past(ir_sh_q, 1))
    else $error("Instruction update lost the shifted value");
  AST_TOP_BYP: assert property (@(posedge tck) disable iff (!trst_n)
    ir_q[`SCTP_IR_W-1] |-> sel_byp && dr_len == `SCTP_LEN_BYP)
    else $error("Top bit set did not select bypass");
  AST_BSCAN_BYP: assert property (@(posedge tck) disable iff (!trst_n)
    (ir_q == `SCTP_OP_EXTEST || ir_q == `SCTP_OP_SAMPLE) |-> sel_byp)
    else $error("Boundary-scan instruction did not select bypass");
  AST_BYP_PATH: assert property (@(posedge tck) disable iff (!trst_n)
    (sel_byp && st_q == SCTP_SHDR && !tms) ##1 (st_q == SCTP_SHDR && sel_byp)
    |-> sh_q[0] == $past(tdi, 1))
    else $error("Bypass path is not one bit long");
  AST_STAT_CAP: assert property (@(posedge tck) disable iff (!trst_n)
    (st_q == SCTP_CDR && sel_stat) |=> sh_q[`SCTP_CMP_N-1:0] == $past(cmp_tck_q, 1))
    else $error("Status capture missed comparator word");
  AST_PROG_CFG: assert property (@(posedge tck) disable iff (!trst_n)
    (wr_ok && op_is_pc) |=> cfg_mem[$past(caddr_q, 1)] == $past(cdata_q, 1))
    else $error("Configuration row not programmed");
  AST_OE_SHIFT: assert property (@(posedge tck) disable iff (!trst_n)
    (st_q == SCTP_SHDR) ##1 (st_q == SCTP_SHDR) |-> link_out.tdo_oe)
    else $error("Output enable low while shifting");

  AST_PEN_SET: assert property (@(posedge tck) disable iff (!trst_n)
    (exec && ir_q == `SCTP_OP_PROG_EN) |=> prog_en_q)
    else $error("Program enable not set");

  AST_PEN_CLR: assert property (@(posedge tck) disable iff (!trst_n)
    (exec && ir_q == `SCTP_OP_PROG_DIS) |=> !prog_en_q)
    else $error("Program enable not cleared");

  AST_NO_FUSE: assert property (@(posedge tck) disable iff (!trst_n)
    (exec && !prog_en_q) |=> fuse_q == $past(fuse_q, 1))
    else $error("Fuse changed without program enable");

  AST_PROG_PLD: assert property (@(posedge tck) disable iff (!trst_n)
    (wr_ok && op_is_pp) |=> pld_mem[$past(prow, 1)] == $past(pdata_q, 1))
    else $error("Logic array row not programmed");

  AST_PROG_UES: assert property (@(posedge tck) disable iff (!trst_n)
    (wr_ok && op_is_pu) |=> ues_mem == $past(ues_q, 1))
    else $error("User word not programmed");

  AST_ID_CAP: assert property (@(posedge tck) disable iff (!trst_n)
    (st_q == SCTP_CDR && sel_id) |=> sh_q[`SCTP_ID_W-1:0] == ID_CODE)
    else $error("Identification capture wrong");

  AST_TDO_DR: assert property (@(posedge tck) disable iff (!trst_n)
    (st_q == SCTP_SHDR) |-> link_out.tdo == sh_q[0])
    else $error("Serial out does not show data path bit");

  AST_TDO_IR: assert property (@(posedge tck) disable iff (!trst_n)
    (st_q == SCTP_SHIR) |-> link_out.tdo == ir_sh_q[0])
    else $error("Serial out does not show instruction bit");

  AST_OE_IDLE: assert property (@(posedge tck) disable iff (!trst_n)
    (st_q == SCTP_RTI) |-> !link_out.tdo_oe)
    else $error("Output enabled while idle");

  AST_SEL_ONE: assert property (@(posedge tck) disable iff (!trst_n)
    $onehot({sel_id, sel_paddr, sel_pdata, sel_caddr, sel_cdata, sel_stat, sel_ues, sel_byp}))
    else $error("Data path selection not unique");

  AST_TLR_IR: assert property (@(posedge tck) disable iff (!trst_n)
    (st_q == SCTP_TLR) |=> ir_q == `SCTP_OP_IDCODE)
    else $error("Reset state did not restore identification");

  AST_FILT: assert property (@(posedge clock) disable iff (!rst_s_n)
    (ce && cmp_agree) |=> filt_q == $past(c3_q, 1))
    else $error("Comparator filter did not accept agreed word");

endmodule : sctp_top

// [tb/sctp_prog_model.sv]
`timescale 1ns/1ps

// ==========================================================
// Programmer model: link clock runs only inside frames
module sctp_prog_model (
  // Link toward the device
  output logic                          tck,
  output sctp_pkg::sctp_link_in_t       link_in,
  input  wire sctp_pkg::sctp_link_out_t link_out
);
  import sctp_pkg::*;

  logic last_q;
  logic tdo_w;

  // Released line shows the inverse of its last value
  assign tdo_w = link_out.tdo_oe ? link_out.tdo : ~last_q;

  always @(link_out)
  begin
    if (link_out.tdo_oe)
      last_q = link_out.tdo;
  end

  initial
  begin
    tck     = 1'b0;
    link_in = '0;
    last_q  = 1'b0;
  end

  // One link clock; inputs change just after the falling edge
  task automatic step(input logic m, input logic d, output logic q);
    #1;
    q = tdo_w;
    link_in.tms = m;
    link_in.tdi = d;
    #39 tck = 1'b1;
    #40 tck = 1'b0;
  endtask : step

  task automatic tlr();
    logic q;
    repeat (6) step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : tlr

  // Device alone in its chain, so only its own lengths count
  task automatic scan(input logic ir, input logic [80:0] din, input int n,
                      output logic [80:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], dout[i]);
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
  endtask : scan
endmodule : sctp_prog_model

// [tb/sctp_bench.sv]
`timescale 1ns/1ps
`include "sctp_params.svh"

module sctp_bench;
  import sctp_pkg::*;

  localparam logic [31:0] ID_VAL = 32'h5A3C_96E1; // Arbitrary value
  localparam logic [40:0] PAT    = 41'h1_3579_BDF0_2;

  logic           clock;
  logic           rst_n;
  logic           ce;
  logic [11:0]    cmp_in;
  logic           tck;
  sctp_link_in_t  link_in;
  sctp_link_out_t link_out;
  logic           safe_state;
  logic [80:0]    dout;
  int             n_fail;
  int             n_compared;

  always #25 clock = ~clock;

  sctp_top #(.ID_CODE(ID_VAL)) dut_u (
    .clock      (clock),
    .rst_n      (rst_n),
    .ce         (ce),
    .cmp_in     (cmp_in),
    .tck        (tck),
    .link_in    (link_in),
    .link_out   (link_out),
    .safe_state (safe_state)
  );

  sctp_prog_model model_u (
    .tck      (tck),
    .link_in  (link_in),
    .link_out (link_out)
  );

  // ==========================================================
  // Shared helpers
  task automatic check(input logic [80:0] seen, input logic [80:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      n_fail++;
    end
  endtask : check

  task automatic ir(input logic [5:0] code);
    logic [80:0] d;
    model_u.scan(1'b1, {75'h0, code}, 6, d);
  endtask : ir

  task automatic dr(input int n, input logic [80:0] din);
    model_u.scan(1'b0, din, n, dout);
  endtask : dr

  task automatic rd_cfg(input logic [3:0] a);
    ir(`SCTP_OP_ADDR_CFG);
    dr(4, {77'h0, a});
    ir(`SCTP_OP_READ_CFG);
    ir(`SCTP_OP_DATA_CFG);
    dr(41, '0);
  endtask : rd_cfg

  task automatic test_done();
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // ==========================================================
  // Scenarios
  task automatic t_ident();
    logic [80:0] d;
    model_u.scan(1'b1, {75'h0, 6'h3F}, 6, d);
    check(d, 81'h19);
    model_u.tlr();
    dr(32, '0);
    check(dout, {49'h0, ID_VAL});
  endtask : t_ident

  task automatic t_bypass();
    logic [5:0] codes [8];
    codes = '{6'h00, 6'h07, 6'h0F, 6'h15, 6'h1C, 6'h20, 6'h2A, 6'h3F};
    foreach (codes[i])
    begin
      ir(codes[i]);
      dr(8, 81'hB5);
      check(dout, 81'h6A);
    end
  endtask : t_bypass

  task automatic t_status();
    logic [11:0] vals [2];
    vals = '{12'hA5C, 12'h3A1};
    foreach (vals[i])
    begin
      @(negedge clock);
      cmp_in = vals[i];
      repeat (30) @(negedge clock);
      ir(`SCTP_OP_STATUS);
      dr(12, '0);
      check(dout, {69'h0, vals[i]});
    end
  endtask : t_status

  task automatic t_prog();
    ir(`SCTP_OP_PROG_EN);
    repeat (20) @(negedge clock);
    check({80'h0, safe_state}, 81'h1);
    ir(`SCTP_OP_ERASE_CFG);
    ir(`SCTP_OP_ADDR_CFG);
    dr(4, 81'h5);
    ir(`SCTP_OP_DATA_CFG);
    dr(41, {40'h0, PAT});
    ir(`SCTP_OP_PROG_CFG);
    ir(`SCTP_OP_DATA_CFG);
    dr(41, '0);
    rd_cfg(4'h5);
    check(dout, {40'h0, PAT});
    rd_cfg(4'h3);
    check(dout, {40'h0, {41{`SCTP_ERASED_BIT}}});
    ir(`SCTP_OP_PROG_DIS);
    ir(`SCTP_OP_ERASE_CFG);
    rd_cfg(4'h5);
    check(dout, {40'h0, PAT});
    ir(`SCTP_OP_BYPASS);
    repeat (20) @(negedge clock);
    check({80'h0, safe_state}, 81'h0);
  endtask : t_prog

  task automatic t_nvm();
    ir(`SCTP_OP_PROG_EN);
    ir(`SCTP_OP_ERASE_ALL);
    ir(`SCTP_OP_ADDR_PLD);
    dr(75, 81'h200);
    ir(`SCTP_OP_DATA_PLD);
    dr(81, {PAT, PAT[39:0]});
    ir(`SCTP_OP_PROG_PLD);
    ir(`SCTP_OP_DATA_PLD);
    dr(81, '0);
    check(dout, {PAT, PAT[39:0]});
    ir(`SCTP_OP_READ_PLD);
    ir(`SCTP_OP_DATA_PLD);
    dr(81, '0);
    check(dout, {PAT, PAT[39:0]});
    ir(`SCTP_OP_SHIFT_UES);
    dr(16, 81'hC3A5);
    check(dout, 81'hFFFF);
    ir(`SCTP_OP_PROG_UES);
    ir(`SCTP_OP_SHIFT_UES);
    dr(16, '0);
    check(dout, 81'hC3A5);
    ir(`SCTP_OP_PROG_FUSE);
    ir(`SCTP_OP_SHIFT_UES);
    dr(16, '0);
    check(dout, 81'h0);
    ir(`SCTP_OP_ERASE_ALL);
    ir(`SCTP_OP_SHIFT_UES);
    dr(16, '0);
    check(dout, 81'hFFFF);
    ir(`SCTP_OP_PROG_DIS);
  endtask : t_nvm

  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    clock      = 1'b0;
    rst_n      = 1'b0;
    ce         = 1'b1;
    cmp_in     = '0;
    n_fail     = 0;
    n_compared = 0;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    model_u.tlr();
    t_ident();
    t_bypass();
    t_status();
    t_prog();
    t_nvm();
    test_done();
  end

  initial
  begin
    #2_000_000;
    n_fail++;
    test_done();
  end
endmodule : sctp_bench
